//--- logic/rf_pulse_timing_generator.sv
// RF pulse envelope generator with APB registers and a list memory.
// Assumes trig_i is synchronous to core_clk_i; one clock throughout.
//
// Overview of operation
// - Square mode free-runs without trigger at 50% duty cycle.
// - Square period comes only from the square-wave rate setting.
// - Free-run mode is the reset default: delay once, then width and period repeat.
// - All delays, widths and periods count in 10 ns clock steps.
// - Both pair modes give exactly two pulses per trigger, then wait.
// - Programmed pair: first pulse after delay from trigger rise.
// - Programmed pair: second delay counts from first pulse rise.
// - Echo pair: first pulse copies the trigger input level.
// - Echo pair: second pulse uses programmed delay and width.
// - Gated mode times pulses from period and width, trigger gates.
// - External mode passes the pulse input straight through.
// - List mode: up to 2047 on/off cycles after a lead delay.
// - Envelope pulses carrier only when enabled, else unmodulated.
// - Each list cycle repeats 1..2047 times; repeats use slots.
// - List on and off times clamp to 20 ns .. 42 s.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module rf_pulse_timing_generator #(
  parameter int unsigned LIST_DEPTH = pulse_gen_pkg::LIST_SLOTS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire pulse_gen_pkg::apb_req_type apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trig_i,
  output logic pulse_o,
  output logic busy_o
);
  import pulse_gen_pkg::*;

  localparam int IW = $clog2(LIST_DEPTH + 1);
  localparam logic [IW-1:0] SLOT_MAX = IW'(LIST_DEPTH);

  cfg_type cfg, next_cfg;
  logic [31:0] stage_on, next_stage_on, stage_off, next_stage_off;
  logic [IW-1:0] list_len, next_list_len, used, next_used;
  logic [31:0] next_prdata;
  logic [31:0] on_mem [LIST_DEPTH];
  logic [31:0] off_mem [LIST_DEPTH];
  logic [IW-1:0] rep_mem [LIST_DEPTH];
  logic wr, rd_setup, mapped, commit, restart, refuse;
  logic [IW-1:0] rep_in;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; errors only on the access phase
  assign pready_o = 1'b1;
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd_setup = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
  assign mapped = apb_i.paddr <= ADDR_STATUS && apb_i.paddr[1:0] == 2'b00;
  assign rep_in = (apb_i.pwdata[IW-1:0] == '0) ? IW'(1) :
                  apb_i.pwdata[IW-1:0];
  // Append refused when the memory or repeat slots would overflow
  assign refuse = apb_i.paddr == ADDR_LIST_REP &&
                  (list_len == SLOT_MAX ||
                   {1'b0, used} + {1'b0, rep_in} > {1'b0, SLOT_MAX});
  assign pslverr_o = apb_i.psel && apb_i.penable && (!mapped ||
                     (apb_i.pwrite && refuse));
  assign commit = wr && apb_i.paddr == ADDR_LIST_REP && !refuse;
  // Any control write restarts the sequencer cleanly
  assign restart = wr && apb_i.paddr == ADDR_CTRL;

  // Register next values
  always_comb begin
    next_cfg = cfg;
    next_stage_on = stage_on;
    next_stage_off = stage_off;
    next_list_len = list_len;
    next_used = used;
    next_prdata = prdata_o;
    if (wr) begin
      case (apb_i.paddr)
        ADDR_CTRL: begin
          next_cfg.mod_en = apb_i.pwdata[CTRL_EN_BIT];
          next_cfg.mode = mode_type'(apb_i.pwdata[CTRL_MODE_LSB +: 3]);
          if (apb_i.pwdata[CTRL_CLR_BIT]) begin
            next_list_len = '0;
            next_used = '0;
          end
        end
        ADDR_SQ_HALF: next_cfg.sq_half = apb_i.pwdata;
        ADDR_PERIOD: next_cfg.period = apb_i.pwdata;
        ADDR_DELAY: next_cfg.delay = apb_i.pwdata;
        ADDR_WIDTH: next_cfg.width = apb_i.pwdata;
        ADDR_DELAY2: next_cfg.delay2 = apb_i.pwdata;
        ADDR_WIDTH2: next_cfg.width2 = apb_i.pwdata;
        ADDR_LIST_DELAY: next_cfg.list_delay = apb_i.pwdata;
        ADDR_LIST_ON: next_stage_on = apb_i.pwdata;
        ADDR_LIST_OFF: next_stage_off = apb_i.pwdata;
        ADDR_LIST_REP: begin
          if (commit) begin
            next_list_len = list_len + IW'(1);
            next_used = used + rep_in;
          end
        end
        default: ;
      endcase
    end
    if (rd_setup) begin
      case (apb_i.paddr)
        ADDR_CTRL: next_prdata = 32'({cfg.mode, cfg.mod_en});
        ADDR_SQ_HALF: next_prdata = cfg.sq_half;
        ADDR_PERIOD: next_prdata = cfg.period;
        ADDR_DELAY: next_prdata = cfg.delay;
        ADDR_WIDTH: next_prdata = cfg.width;
        ADDR_DELAY2: next_prdata = cfg.delay2;
        ADDR_WIDTH2: next_prdata = cfg.width2;
        ADDR_LIST_DELAY: next_prdata = cfg.list_delay;
        ADDR_LIST_ON: next_prdata = stage_on;
        ADDR_LIST_OFF: next_prdata = stage_off;
        ADDR_LIST_LEN: next_prdata = 32'(list_len);
        ADDR_SLOTS: next_prdata = 32'(used);
        ADDR_STATUS: next_prdata = 32'({busy_o, pulse_o});
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg <= '{mod_en: 1'b0, mode: MODE_RST, sq_half: SQ_HALF_RST,
               period: PERIOD_RST, delay: DELAY_RST, width: WIDTH_RST,
               delay2: DELAY2_RST, width2: WIDTH2_RST,
               list_delay: DELAY_RST};
      stage_on <= LIST_MIN_CYC;
      stage_off <= LIST_MIN_CYC;
      list_len <= '0;
      used <= '0;
      prdata_o <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      stage_on <= next_stage_on;
      stage_off <= next_stage_off;
      list_len <= next_list_len;
      used <= next_used;
      prdata_o <= next_prdata;
    end
  end

  // List memory; no reset, contents only valid below list_len
  always_ff @(posedge core_clk_i) begin
    if (commit) begin
      on_mem[list_len] <= stage_on;
      off_mem[list_len] <= stage_off;
      rep_mem[list_len] <= rep_in;
    end
  end

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  logic [1:0] hcnt, next_hcnt;
  logic trig_ok, trig_ok_q, trig_rise;
  assign trig_ok = hcnt == 2'(TRIG_MIN_CYC);
  assign trig_rise = trig_ok && !trig_ok_q;

  // Short glitches never reach the sequencer
  always_comb begin
    next_hcnt = '0;
    if (trig_i) begin
      next_hcnt = trig_ok ? hcnt : hcnt + 2'd1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hcnt <= '0;
      trig_ok_q <= 1'b0;
    end else begin
      hcnt <= next_hcnt;
      trig_ok_q <= trig_ok;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_type state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [IW-1:0] ptr, next_ptr, rep_left, next_rep;
  logic [IW-1:0] nptr;
  logic env, next_pulse;

  // Count load: a phase of n steps stays n cycles (at least one)
  function automatic logic [31:0] len(input logic [31:0] n);
    len = (n == 32'h0000_0000) ? 32'h0000_0000 : n - 32'h0000_0001;
  endfunction

  // List phases held inside the programmable range
  function automatic logic [31:0] clamp(input logic [31:0] n);
    if (n < LIST_MIN_CYC) begin
      clamp = len(LIST_MIN_CYC);
    end else if (n > LIST_MAX_CYC) begin
      clamp = len(LIST_MAX_CYC);
    end else begin
      clamp = len(n);
    end
  endfunction

  // Remaining gap after the on phase; never below one step
  function automatic logic [31:0] gap(input logic [31:0] a,
                                      input logic [31:0] b);
    gap = (a > b) ? len(a - b) : 32'h0000_0000;
  endfunction

  assign nptr = (ptr + IW'(1) == list_len) ? '0 : ptr + IW'(1);

  // Next state, counter and list pointer
  always_comb begin
    next_state = state;
    next_cnt = (cnt != 32'h0000_0000) ? cnt - 32'h0000_0001 : cnt;
    next_ptr = ptr;
    next_rep = rep_left;
    if (restart) begin
      next_state = ST_IDLE;
      next_cnt = '0;
    end else begin
      case (state)
        ST_IDLE: begin
          case (cfg.mode)
            MODE_SQUARE: begin
              next_state = ST_ON;
              next_cnt = len(cfg.sq_half);
            end
            MODE_FREE: begin
              next_state = ST_DLY;
              next_cnt = len(cfg.delay);
            end
            MODE_TRIG, MODE_ADJ_PAIR: begin
              if (trig_rise) begin
                next_state = ST_DLY;
                next_cnt = len(cfg.delay);
              end
            end
            MODE_ECHO_PAIR: begin
              if (trig_rise) begin
                next_state = ST_DLY2;
                next_cnt = len(cfg.delay2);
              end
            end
            MODE_GATED: begin
              if (trig_ok) begin
                next_state = ST_ON;
                next_cnt = len(cfg.width);
              end
            end
            MODE_LIST: begin
              if (list_len != '0) begin
                next_state = ST_DLY;
                next_cnt = len(cfg.list_delay);
                next_ptr = '0;
                next_rep = rep_mem[0];
              end
            end
            default: ;
          endcase
        end
        ST_DLY: begin
          if (cnt == '0) begin
            next_state = ST_ON;
            next_cnt = (cfg.mode == MODE_LIST) ? clamp(on_mem[ptr]) :
                       len(cfg.width);
          end
        end
        ST_ON: begin
          if (cnt == '0) begin
            next_state = ST_OFF;
            case (cfg.mode)
              MODE_SQUARE: next_cnt = len(cfg.sq_half);
              MODE_TRIG: next_state = ST_IDLE;
              MODE_ADJ_PAIR: begin
                next_state = ST_DLY2;
                next_cnt = gap(cfg.delay2, cfg.width);
              end
              MODE_GATED: begin
                if (!trig_ok) begin
                  next_state = ST_IDLE;
                end
                next_cnt = gap(cfg.period, cfg.width);
              end
              MODE_LIST: next_cnt = clamp(off_mem[ptr]);
              default: next_cnt = gap(cfg.period, cfg.width);
            endcase
          end
        end
        ST_OFF: begin
          if (cnt == '0) begin
            next_state = ST_ON;
            case (cfg.mode)
              MODE_SQUARE: next_cnt = len(cfg.sq_half);
              MODE_GATED: begin
                next_cnt = len(cfg.width);
                if (!trig_ok) begin
                  next_state = ST_IDLE;
                end
              end
              MODE_LIST: begin
                if (rep_left > IW'(1)) begin
                  next_rep = rep_left - IW'(1);
                  next_cnt = clamp(on_mem[ptr]);
                end else begin
                  next_ptr = nptr;
                  next_rep = rep_mem[nptr];
                  next_cnt = clamp(on_mem[nptr]);
                end
              end
              default: next_cnt = len(cfg.width);
            endcase
          end
        end
        ST_DLY2: begin
          if (cnt == '0) begin
            next_state = ST_ON2;
            next_cnt = len(cfg.width2);
          end
        end
        ST_ON2: begin
          if (cnt == '0) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Envelope select; carrier stays on when modulation is off
  always_comb begin
    case (cfg.mode)
      MODE_EXT: env = trig_i;
      MODE_ECHO_PAIR: env = (state == ST_ON2) ||
                            trig_i;
      default: env = state == ST_ON || state == ST_ON2;
    endcase
    next_pulse = cfg.mod_en ? env : 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      ptr <= '0;
      rep_left <= '0;
      pulse_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ptr <= next_ptr;
      rep_left <= next_rep;
      pulse_o <= next_pulse;
      busy_o <= next_state != ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_short_trig;
    !trig_i ##1 trig_i ##1 !trig_i;
  endsequence
  sequence s_adj_start;
    cfg.mode == MODE_ADJ_PAIR && state == ST_IDLE && trig_rise && !restart;
  endsequence

  property p_unmod;
    !cfg.mod_en |=> pulse_o;
  endproperty
  a_unmod: assert property (p_unmod) else $error("carrier modulated");

  property p_ext;
    cfg.mod_en && cfg.mode == MODE_EXT |=> pulse_o == $past(trig_i);
  endproperty
  a_ext: assert property (p_ext) else $error("ext not passed");

  property p_square;
    cfg.mode == MODE_SQUARE && state == ST_ON && cnt == '0 && !restart
      |=> state == ST_OFF && cnt == len(cfg.sq_half);
  endproperty
  a_square: assert property (p_square) else $error("square halves");

  property p_short;
    s_short_trig |-> !trig_ok;
  endproperty
  a_short: assert property (p_short) else $error("glitch accepted");

  property p_adj_first;
    s_adj_start |=> state == ST_DLY && cnt == len(cfg.delay);
  endproperty
  a_adj_first: assert property (p_adj_first) else $error("delay 1");

  property p_pair_end;
    state == ST_ON2 && cnt == '0 && !restart |=> state == ST_IDLE;
  endproperty
  a_pair_end: assert property (p_pair_end) else $error("third pulse");

  property p_retrig;
    cfg.mode == MODE_TRIG && state == ST_ON && !restart
      |=> state == ST_ON || state == ST_OFF || state == ST_IDLE;
  endproperty
  a_retrig: assert property (p_retrig) else $error("retriggered");

  property p_gate_stop;
    cfg.mode == MODE_GATED && state == ST_ON && cnt == '0 && !trig_ok &&
      !restart |=> state == ST_IDLE ##1 (state == ST_IDLE || $past(trig_ok));
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate");

  property p_list_rep;
    cfg.mode == MODE_LIST && state == ST_OFF && cnt == '0 &&
      rep_left > IW'(1) && !restart
      |=> state == ST_ON && rep_left == $past(rep_left) - IW'(1);
  endproperty
  a_list_rep: assert property (p_list_rep) else $error("repeat");

endmodule

`default_nettype wire

//--- logic/pulse_gen_pkg.sv
// Constants and types for the RF pulse timing generator.
// Assumes a 100 MHz core clock and an APB register bus.
`default_nettype none

package pulse_gen_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIG_MIN_NS = 20;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int LIST_MIN_NS = 20;
  localparam logic [31:0] LIST_MIN_CYC = 32'((LIST_MIN_NS + CLK_PERIOD_NS
                                         - 1) / CLK_PERIOD_NS);
  localparam longint LIST_MAX_S = 42;
  localparam logic [31:0] LIST_MAX_CYC = 32'(LIST_MAX_S * 64'd1_000_000_000
                                         / CLK_PERIOD_NS);
  localparam int LIST_SLOTS = 2047;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SQ_HALF = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_DELAY2 = 8'h14;
  localparam logic [7:0] ADDR_WIDTH2 = 8'h18;
  localparam logic [7:0] ADDR_LIST_DELAY = 8'h1C;
  localparam logic [7:0] ADDR_LIST_ON = 8'h20;
  localparam logic [7:0] ADDR_LIST_OFF = 8'h24;
  localparam logic [7:0] ADDR_LIST_REP = 8'h28;
  localparam logic [7:0] ADDR_LIST_LEN = 8'h2C;
  localparam logic [7:0] ADDR_SLOTS = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;

  // CTRL fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CLR_BIT = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SQUARE = 3'h0,
    MODE_FREE = 3'h1,
    MODE_TRIG = 3'h2,
    MODE_ADJ_PAIR = 3'h3,
    MODE_ECHO_PAIR = 3'h4,
    MODE_GATED = 3'h5,
    MODE_EXT = 3'h6,
    MODE_LIST = 3'h7
  } mode_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_DLY = 6'b00_0010,
    ST_ON = 6'b00_0100,
    ST_OFF = 6'b00_1000,
    ST_DLY2 = 6'b01_0000,
    ST_ON2 = 6'b10_0000
  } state_type;

  typedef struct packed {
    logic mod_en;
    mode_type mode;
    logic [31:0] sq_half;
    logic [31:0] period;
    logic [31:0] delay;
    logic [31:0] width;
    logic [31:0] delay2;
    logic [31:0] width2;
    logic [31:0] list_delay;
  } cfg_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // ----------------------------------------------------------------
  // Reset values (counts of 10 ns steps)
  // ----------------------------------------------------------------
  localparam mode_type MODE_RST = MODE_FREE;
  localparam logic [31:0] SQ_HALF_RST = 32'h0000_1388;
  localparam logic [31:0] PERIOD_RST = 32'h0000_2710;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0960;
  localparam logic [31:0] DELAY2_RST = 32'h0000_1388;
  localparam logic [31:0] WIDTH2_RST = 32'h0000_0960;

endpackage

`default_nettype wire

//--- test/pulse_far_side.sv
// Far-side model: trigger or gate source, and RF modulator.
// Assumes the bench calls run() while the core clock is running.
`timescale 1ns/1ns
`default_nettype none

module pulse_far_side (
  input wire logic core_clk_i,
  input wire logic env_i,
  output logic trig_o
);
  // ------------------------------------------------------------
  // Trigger drive and envelope capture
  // ------------------------------------------------------------
  // Line idles low between triggers
  initial begin
    trig_o = 1'b0;
  end

  // Trigger high for len cycles; envelope sampled mid-cycle
  task automatic run(input int len, input int n,
                     output logic [63:0] tr);
    tr = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      trig_o <= (i < len);
      @(negedge core_clk_i);
      tr[i] = env_i;  // High means RF on
    end
    @(posedge core_clk_i);
    trig_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- test/rf_pulse_timing_generator_test.sv
// Self-checking bench for the pulse timing generator.
// Assumes the far-side model in pulse_far_side and the design package.
`timescale 1ns/1ns
`default_nettype none

module rf_pulse_timing_generator_test;
  import pulse_gen_pkg::*;
  logic core_clk;
  logic rst_n;
  apb_req_type apb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig;
  logic pulse;
  logic busy;
  int err_count = 0;
  int checks = 0;
  logic [63:0] tr;
  logic [31:0] rd;
  logic err;

  rf_pulse_timing_generator dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .trig_i(trig), .pulse_o(pulse), .busy_o(busy)
  );

  pulse_far_side far (.core_clk_i(core_clk), .env_i(pulse), .trig_o(trig));

  // ------------------------------------------------------------
  // Clock, checks and bus access
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits a bounded time for pready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      chk(64'(pready), 64'h1);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  function automatic logic [63:0] span(input int lo, input int len);
    return ((64'h1 << len) - 64'h1) << lo;
  endfunction

  // Select a mode; CTRL write idles the sequencer, so let it settle
  task automatic go(input mode_type m, input logic en, input int len,
                    input int n);
    bus(1'b1, ADDR_CTRL, (32'(m) << CTRL_MODE_LSB) | 32'(en));
    repeat (3) @(posedge core_clk);
    far.run(len, n, tr);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({62'h0, pulse, busy}, 64'h2);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(64'(rd), 64'(32'(MODE_FREE) << CTRL_MODE_LSB));
    bus(1'b0, 8'h38, 32'h0);
    chk(64'({err, rd}), 64'h1_0000_0000);
    $display("test reset done");
  endtask

  task automatic t_square();
    bus(1'b1, ADDR_SQ_HALF, 32'h0000_0003);
    go(MODE_SQUARE, 1'b1, 0, 64);
    chk(64'(tr[50:8] ^ tr[53:11]), span(0, 43));
    chk(64'($countones(tr[55:8])), 64'd24);
    $display("test square done");
  endtask

  task automatic t_free();
    bus(1'b1, ADDR_PERIOD, 32'h0000_0008);
    bus(1'b1, ADDR_WIDTH, 32'h0000_0003);
    bus(1'b1, ADDR_DELAY, 32'h0000_0000);
    go(MODE_FREE, 1'b1, 0, 64);
    chk(64'(tr[47:8]), 64'(tr[55:16]));
    chk(64'($countones(tr[23:16])), 64'd3);
    $display("test free run done");
  endtask

  // Walk: trigger in c0,c1; pulse high D+4 for W cycles
  task automatic t_trig();
    bus(1'b1, ADDR_DELAY, 32'h0000_0002);
    go(MODE_TRIG, 1'b1, 2, 40);
    chk(tr, span(6, 3));
    go(MODE_TRIG, 1'b1, 1, 24);
    chk(tr, 64'h0);
    go(MODE_TRIG, 1'b0, 2, 24);
    chk(tr, span(0, 24));
    $display("test triggered done");
  endtask

  // Programmed pair: second pulse counts from the first pulse's rise; echo pair: from the qualified trigger
  task automatic t_pairs();
    bus(1'b1, ADDR_DELAY2, 32'h0000_0006);
    bus(1'b1, ADDR_WIDTH2, 32'h0000_0002);
    go(MODE_ADJ_PAIR, 1'b1, 2, 40);
    chk(tr, span(6, 3) | span(12, 2));
    bus(1'b1, ADDR_DELAY2, 32'h0000_000A);
    bus(1'b1, ADDR_WIDTH2, 32'h0000_0004);
    go(MODE_ECHO_PAIR, 1'b1, 3, 48);
    chk(64'(tr[9:0]), span(1, 3));
    chk(64'($countones(tr)), 64'd7);
    $display("test pairs done");
  endtask

  // Gate open 13 cycles; nothing may follow the last pulse
  task automatic t_gated();
    bus(1'b1, ADDR_PERIOD, 32'h0000_0006);
    bus(1'b1, ADDR_WIDTH, 32'h0000_0002);
    go(MODE_GATED, 1'b1, 13, 64);
    chk(64'(tr[63:32]), 64'h0);
    chk(64'($countones(tr) >= 4 && $countones(tr) % 2 == 0), 64'h1);
    go(MODE_EXT, 1'b1, 5, 16);
    chk(tr, span(1, 5));
    $display("test gated and external done");
  endtask

  // Two entries play 3/4 twice then 2/2; the 1-step on time clamps to 2
  task automatic t_list();
    bus(1'b1, ADDR_CTRL, 32'h0000_0010);
    bus(1'b1, ADDR_LIST_ON, 32'h0000_0003);
    bus(1'b1, ADDR_LIST_OFF, 32'h0000_0004);
    bus(1'b1, ADDR_LIST_REP, 32'h0000_0002);
    bus(1'b1, ADDR_LIST_ON, 32'h0000_0001);
    bus(1'b1, ADDR_LIST_OFF, 32'h0000_0002);
    bus(1'b1, ADDR_LIST_REP, 32'h0000_0001);
    bus(1'b0, ADDR_LIST_LEN, 32'h0);
    chk(64'(rd), 64'h2);
    go(MODE_LIST, 1'b1, 0, 64);
    chk(64'(tr[45:0] ^ tr[63:18]), 64'h0);
    chk(64'($countones(tr[35:0])), 64'd16);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(64'(rd[1]), 64'h1);
    bus(1'b1, ADDR_LIST_REP, 32'(2047 - 2));
    chk(64'(err), 64'h1);
    bus(1'b1, ADDR_LIST_REP, 32'(2047 - 3));
    chk(64'(err), 64'h0);
    bus(1'b0, ADDR_SLOTS, 32'h0);
    chk(64'(rd), 64'd2047);
    $display("test list done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    apb = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_square();
    t_free();
    t_trig();
    t_pairs();
    t_gated();
    t_list();
    wrap_up();
  end
endmodule

`default_nettype wire
